// >>> shared/encoder_measure_pkg.sv
// constants shared by the encoder period/frequency block and its divider
// assumes a 25 MHz aclk and a 10 ns measurement time base
package encoder_measure_pkg;
    // clock and time base
    localparam int CLK_NS = 40;
    localparam int BASE_NS = 10;
    localparam logic [3:0] UNITS_PER_CLK = 4'(CLK_NS / BASE_NS);
    // period timeout, 21 s
    localparam longint TIMEOUT_S = 21;
    localparam longint TIMEOUT_CYC = (TIMEOUT_S * 64'd1000000000) / CLK_NS;
    localparam logic [31:0] PERIOD_MAX = 32'h8000_0000;
    localparam logic [31:0] CNT_SAT = 32'hFFFF_FFFF;
    // valid period limits, 0.20 us diff / 1 us single ended
    localparam int PERIOD_MIN_DIFF_NS = 200;
    localparam int PERIOD_MIN_SE_NS = 1000;
    // period scaling settings in ns and divisors in 10 ns units
    localparam logic [31:0] PSCALE_100 = 32'h0000_0064;
    localparam logic [31:0] PSCALE_500 = 32'h0000_01F4;
    localparam int NSCALES = 3;
    localparam logic [5:0] SCALE_DIV [NSCALES] = '{6'h01, 6'h0A, 6'h32};
    // frequency scaling: 1 -> 1 Hz, else 0.01 Hz; ticks of 10 ns per second
    localparam logic [31:0] FSCALE_1HZ = 32'h0000_0001;
    localparam logic [33:0] K_1HZ = 34'h0_05F5_E100;
    localparam logic [33:0] K_CENTI_HZ = 34'h2_540B_E400;
    // divider widths
    localparam int DIVIDEND_W = 96;
    localparam int DIVISOR_W = 64;
    // register byte offsets
    localparam logic [7:0] OFS_PSCALE = 8'h00;
    localparam logic [7:0] OFS_FSCALE = 8'h04;
    localparam logic [7:0] OFS_FWINDOW = 8'h08;
    localparam logic [7:0] OFS_NUMER = 8'h0C;
    localparam logic [7:0] OFS_DENOM = 8'h10;
    localparam logic [7:0] OFS_PERIOD = 8'h14;
    localparam logic [7:0] OFS_FREQ = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1C;
    // reset values
    localparam logic [31:0] RST_PSCALE = 32'h0000_000A;
    localparam logic [31:0] RST_FSCALE = 32'h0000_0064;
    localparam logic [31:0] RST_FWINDOW = 32'h000F_4240; // 10 ms in 10 ns units
    localparam logic [31:0] RST_NUMER = 32'h0000_0001;
    localparam logic [31:0] RST_DENOM = 32'h0000_0001;
    // status bits and AXI response codes
    localparam int ST_TIMEOUT = 0;
    localparam int ST_ARMED = 1;
    localparam int ST_DIV_BUSY = 2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> tb/encoder_measure_properties.sv
// checker for the encoder period block, top-level ports only
// assumes one aclk domain and a synchronous active-low aresetn
`timescale 1ns/1ns
module encoder_measure_properties
    import encoder_measure_pkg::*;
#(
    parameter longint TIMEOUT_CYCLES = TIMEOUT_CYC
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic track_a,
    input wire logic cycle_tick,
    input wire logic [31:0] period_value,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arready,
    input wire logic s_axi_arvalid,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // margin covers the input synchroniser and the output register
    localparam logic [31:0] TMO_CHECK = 32'(TIMEOUT_CYCLES + 8);
    logic [31:0] quiet_r;
    logic a_q_r;
    logic armed_r;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // cycles since the last raw rising edge on the pin
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            quiet_r <= 32'h0000_0000;
            a_q_r <= 1'b0;
            armed_r <= 1'b0;
        end
        else
        begin
            a_q_r <= track_a;
            if (track_a && !a_q_r)
            begin
                quiet_r <= 32'h0000_0000;
                armed_r <= 1'b1;
            end
            else if (quiet_r != CNT_SAT)
                quiet_r <= quiet_r + 32'h0000_0001; // saturates, never wraps
        end
    end

    chk_period_hold: assert property (
        $changed(period_value) |-> $past(cycle_tick) || period_value == PERIOD_MAX)
        else $error("period output moved without a tick");
    chk_timeout_max: assert property (
        armed_r && quiet_r == TMO_CHECK |-> period_value == PERIOD_MAX)
        else $error("period output not saturated after timeout");
    chk_write_resp: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    chk_bresp_stable: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    chk_bvalid_clear: assert property (
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
        else $error("write channel not released");
    chk_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("new write accepted during response");
    chk_read_latency: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read data late");
    chk_rdata_stable: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
endmodule // encoder_measure_properties

bind encoder_period_frequency_measure encoder_measure_properties
    #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) i_encoder_measure_properties (
    .aclk(aclk), .aresetn(aresetn), .track_a(track_a), .cycle_tick(cycle_tick),
    .period_value(period_value), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arready(s_axi_arready), .s_axi_arvalid(s_axi_arvalid), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// >>> tb/tb.sv
// self-checking bench for the encoder period and frequency block
// assumes the timeout parameter is shortened to 200 cycles
`timescale 1ns/1ns
module tb;
    import encoder_measure_pkg::*;
    localparam longint TMO = 200;
    logic aclk, aresetn, cycle_tick, track_a, enc_run, awvalid, awready, wvalid, wready;
    logic bvalid, bready, arvalid, arready, rvalid, rready;
    logic [15:0] enc_period;
    logic [31:0] period_value, freq_value, wdata, rdata, rd;
    logic [7:0] awaddr, araddr;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rs;
    int errors, n_tests, cyc;

    encoder_period_frequency_measure #(.TIMEOUT_CYCLES(TMO)) i_encoder_period_frequency_measure (
        .aclk(aclk), .aresetn(aresetn), .track_a(track_a), .cycle_tick(cycle_tick),
        .period_value(period_value), .freq_value(freq_value), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    track_a_encoder_model i_track_a_encoder_model (.aclk(aclk), .run(enc_run),
        .period_clks(enc_period), .track_a(track_a));

    always #20 aclk = ~aclk;

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic finish_test;
        $display("errors=%0d n_tests=%0d", errors, n_tests);
        if (errors == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // hang guard, well beyond the few thousand cycles the tests need
    always @(posedge aclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            errors++;
            finish_test();
        end
    end

    // bready raised only once bvalid is seen, so the hold rule is exercised
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b1;
        @(posedge aclk);
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b1;
        @(posedge aclk);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    task automatic tick;
        @(posedge aclk);
        cycle_tick <= 1'b1;
        @(posedge aclk);
        cycle_tick <= 1'b0;
        @(posedge aclk);
    endtask

    // reset values, unmapped and read-only places
    task automatic test_regs;
        logic [7:0] ofs [5] = '{OFS_PSCALE, OFS_FSCALE, OFS_FWINDOW, OFS_NUMER, OFS_DENOM};
        logic [31:0] rv [5] = '{RST_PSCALE, RST_FSCALE, RST_FWINDOW, RST_NUMER, RST_DENOM};
        for (int i = 0; i < 5; i++)
        begin
            axi_read(ofs[i], rd, rs);
            check(rd, rv[i]);
        end
        axi_write(8'h40, 32'h1234_5678, rs);
        check(32'(rs), 32'(RESP_SLVERR));
        axi_read(8'h40, rd, rs);
        check({rd[31:2], rs}, {30'h0000_0000, RESP_SLVERR});
        axi_write(OFS_PERIOD, 32'hFFFF_FFFF, rs);
        axi_read(OFS_PERIOD, rd, rs);
        check(rd, 32'h0000_0000);
    endtask

    // 125-cycle period is 500 units of 10 ns
    task automatic test_scaling;
        logic [31:0] sc [3] = '{PSCALE_100, PSCALE_500, RST_PSCALE};
        logic [31:0] ex [3] = '{32'h0000_0032, 32'h0000_000A, 32'h0000_01F4};
        enc_period <= 16'h007D;
        enc_run <= 1'b1;
        for (int i = 0; i < 3; i++)
        begin
            axi_write(OFS_PSCALE, sc[i], rs);
            repeat (300) @(posedge aclk);
            tick();
            check(period_value, ex[i]);
        end
    endtask

    // two speeds inside one controller cycle: only the later one counts
    task automatic test_last_period;
        enc_period <= 16'h0014;
        repeat (100) @(posedge aclk);
        enc_period <= 16'h001E;
        repeat (100) @(posedge aclk);
        tick();
        check(period_value, 32'h0000_0078);
    endtask

    // stall the encoder: hold, then saturate, then recover
    task automatic test_hold_timeout;
        enc_run <= 1'b0;
        repeat (5) @(posedge aclk);
        tick();
        check(period_value, 32'h0000_0078);
        repeat (TMO + 20) @(posedge aclk);
        check(period_value, PERIOD_MAX);
        axi_read(OFS_STATUS, rd, rs);
        check(rd, 32'(1) << ST_TIMEOUT);
        tick();
        check(period_value, PERIOD_MAX);
        enc_run <= 1'b1;
        repeat (100) @(posedge aclk);
        tick();
        check(period_value, 32'h0000_0078);
    endtask

    // 25-cycle period is 1 MHz; normalised by 3/2 in both frequency units
    task automatic test_freq;
        logic [31:0] fs [2] = '{FSCALE_1HZ, RST_FSCALE};
        longint k;
        enc_period <= 16'h0019;
        axi_write(OFS_FWINDOW, 32'h0000_07D0, rs);
        axi_write(OFS_NUMER, 32'h0000_0003, rs);
        axi_write(OFS_DENOM, 32'h0000_0002, rs);
        for (int i = 0; i < 2; i++)
        begin
            axi_write(OFS_FSCALE, fs[i], rs);
            k = (i == 0) ? 64'd100000000 : 64'd10000000000;
            repeat (1300) @(posedge aclk);
            check(freq_value, 32'(k * 3 / (100 * 2)));
            axi_read(OFS_FREQ, rd, rs);
            check(rd, 32'(k * 3 / (100 * 2)));
        end
    endtask

    initial
    begin
        aclk = 1'b0;
        aresetn = 1'b0;
        cycle_tick = 1'b0;
        enc_run = 1'b0;
        enc_period = 16'h0014;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0000_0000;
        wstrb = 4'hF;
        errors = 0;
        n_tests = 0;
        cyc = 0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        test_regs();
        test_scaling();
        test_last_period();
        test_hold_timeout();
        test_freq();
        finish_test();
    end
endmodule // tb

// >>> tb/track_a_encoder_model.sv
// square-wave encoder on track A, period given in aclk cycles
// assumes aclk from the bench; output skewed 7 ns so it is not edge-aligned
`timescale 1ns/1ns
module track_a_encoder_model
(
    input wire logic aclk,
    input wire logic run,
    input wire logic [15:0] period_clks,
    output logic track_a
);
    logic [15:0] phase_r = 16'h0000;

    initial track_a = 1'b0;
    // stopped encoder rests low, high for the first half of each period
    always @(posedge aclk)
    begin
        if (!run)
        begin
            phase_r <= 16'h0000;
            track_a <= #7 1'b0;
        end
        else
        begin
            phase_r <= (phase_r + 16'h0001 >= period_clks) ? 16'h0000 : phase_r + 16'h0001;
            track_a <= #7 (phase_r < (period_clks >> 1));
        end
    end
endmodule // track_a_encoder_model

// >>> verilog/encoder_period_frequency_measure.sv
// encoder track A period and normalised frequency measurement, AXI4-Lite slave
// assumes cycle_tick is a one-clock pulse from controller logic on aclk,
// and track_a comes straight from a pin
`timescale 1ns/1ns
module encoder_period_frequency_measure
    import encoder_measure_pkg::*;
#(
    parameter longint TIMEOUT_CYCLES = TIMEOUT_CYC
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic track_a,
    input wire logic cycle_tick,
    output logic [31:0] period_value,
    output logic [31:0] freq_value,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // byte-lane merge, used by every writable register
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
        input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
            if (strb[i])
                r[i*8 +: 8] = d[i*8 +: 8];
        return r;
    endfunction

    function automatic logic is_mapped(input logic [7:0] a);
        return a[1:0] == 2'h0 && a <= OFS_STATUS;
    endfunction

    logic [31:0] pscale_r;
    logic [31:0] fscale_r;
    logic [31:0] fwindow_r;
    logic [31:0] freq_norm_numerator_r;
    logic [31:0] freq_norm_denominator_r;
    logic a_s1_r;
    logic a_s2_r;
    logic a_s3_r;
    logic a_lvl_r;
    logic rise;
    logic armed_r;
    logic timed_out_r;
    logic captured_r;
    logic [31:0] last_period_r;
    logic [31:0] idle_clk_r;
    logic [31:0] cnt_r [NSCALES];
    logic [5:0] sub_r [NSCALES];
    logic [1:0] sel;
    logic [31:0] sel_cnt;
    logic timeout_hit;
    logic [31:0] win_cnt_r;
    logic win_end;
    logic seen_first_r;
    logic [31:0] first_t_r;
    logic [31:0] last_t_r;
    logic [23:0] periods_r;
    logic div_start_r;
    logic [DIVIDEND_W-1:0] dividend_r;
    logic [DIVISOR_W-1:0] divisor_r;
    logic div_busy;
    logic div_done;
    logic [DIVIDEND_W-1:0] quotient;
    logic aw_hold_r;
    logic w_hold_r;
    logic [7:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic wr_go;

    // pin synchroniser; the level moves only when stages two and three agree
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            a_s1_r <= 1'b0;
            a_s2_r <= 1'b0;
            a_s3_r <= 1'b0;
            a_lvl_r <= 1'b0;
        end
        else
        begin
            a_s1_r <= track_a;
            a_s2_r <= a_s1_r;
            a_s3_r <= a_s2_r;
            if (a_s2_r == a_s3_r)
                a_lvl_r <= a_s3_r;
        end
    end

    assign rise = a_s2_r && a_s3_r && !a_lvl_r;

    // select the period unit; unknown settings fall back to 10 ns
    always_comb
    begin
        if (pscale_r == PSCALE_100)
            sel = 2'h1;
        else if (pscale_r == PSCALE_500)
            sel = 2'h2;
        else
            sel = 2'h0;
        sel_cnt = cnt_r[sel];
    end

    // one timer per unit, avoids dividing the captured period afterwards
    generate
        for (genvar s = 0; s < NSCALES; s++)
        begin : g_scale
            logic [6:0] acc;
            logic [6:0] inc;
            logic [32:0] sum;
            always_comb
            begin
                acc = 7'(sub_r[s]) + 7'(UNITS_PER_CLK);
                inc = acc / 7'(SCALE_DIV[s]);
                sum = 33'(cnt_r[s]) + 33'(inc);
            end
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                begin
                    cnt_r[s] <= '0;
                    sub_r[s] <= '0;
                end
                else if (rise || timeout_hit)
                begin
                    // the edge clock already belongs to the new period, else 4 units short
                    cnt_r[s] <= 32'(7'(UNITS_PER_CLK) / 7'(SCALE_DIV[s]));
                    sub_r[s] <= 6'(7'(UNITS_PER_CLK) % 7'(SCALE_DIV[s]));
                end
                else
                begin
                    cnt_r[s] <= sum[32] ? CNT_SAT : sum[31:0];
                    sub_r[s] <= 6'(acc % 7'(SCALE_DIV[s]));
                end
            end
        end
    endgenerate

    // idle timer in clocks; the timeout clears armed_r, so it fires exactly once
    assign timeout_hit = armed_r && (64'(idle_clk_r) + 64'h1 >= 64'(TIMEOUT_CYCLES));

    always_ff @(posedge aclk)
    begin
        if (!aresetn || rise || !armed_r)
            idle_clk_r <= '0;
        else if (idle_clk_r != CNT_SAT)
            idle_clk_r <= idle_clk_r + 32'h1;
    end

    // capture of complete periods; a first edge only arms the timer
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            armed_r <= 1'b0;
            timed_out_r <= 1'b0;
            last_period_r <= '0;
        end
        else if (rise)
        begin
            armed_r <= 1'b1;
            timed_out_r <= 1'b0;
            if (armed_r)
                last_period_r <= sel_cnt;
        end
        else if (timeout_hit)
        begin
            armed_r <= 1'b0;
            timed_out_r <= 1'b1;
        end
    end

    // period output: latest period at each cycle tick, held if none arrived until the timeout forces PERIOD_MAX
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            captured_r <= 1'b0;
            period_value <= '0;
        end
        else if (timeout_hit)
        begin
            captured_r <= 1'b0;
            period_value <= PERIOD_MAX;
        end
        else if (cycle_tick)
        begin
            // an edge in the tick clock still counts for this cycle
            if (rise && armed_r)
                period_value <= sel_cnt;
            else if (captured_r)
                period_value <= last_period_r;
            captured_r <= 1'b0;
        end
        else if (rise && armed_r)
            captured_r <= 1'b1;
    end

    // frequency window timer in 10 ns units, free running across cycles
    assign win_end = 33'(win_cnt_r) + 33'(UNITS_PER_CLK) >= 33'(fwindow_r);

    always_ff @(posedge aclk)
    begin
        if (!aresetn || win_end)
            win_cnt_r <= '0;
        else
            win_cnt_r <= win_cnt_r + 32'(UNITS_PER_CLK);
    end

    // count complete periods between first and last rising edge in the window
    always_ff @(posedge aclk)
    begin
        if (!aresetn || win_end)
        begin
            seen_first_r <= 1'b0;
            periods_r <= '0;
            first_t_r <= '0;
            last_t_r <= '0;
        end
        else if (rise)
        begin
            if (!seen_first_r)
            begin
                seen_first_r <= 1'b1;
                first_t_r <= win_cnt_r;
            end
            else
            begin
                periods_r <= periods_r + 24'h1;
                last_t_r <= win_cnt_r;
            end
        end
    end

    // launch periods*K*num / (interval*den); a window ending while busy is lost
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            div_start_r <= 1'b0;
            dividend_r <= '0;
            divisor_r <= '0;
        end
        else
        begin
            div_start_r <= 1'b0;
            if (win_end && periods_r != '0 && !div_busy && freq_norm_denominator_r != '0)
            begin
                div_start_r <= 1'b1;
                dividend_r <= DIVIDEND_W'(periods_r) * DIVIDEND_W'(fscale_r == FSCALE_1HZ
                    ? K_1HZ : K_CENTI_HZ) * DIVIDEND_W'(freq_norm_numerator_r);
                divisor_r <= DIVISOR_W'(last_t_r - first_t_r)
                    * DIVISOR_W'(freq_norm_denominator_r);
            end
        end
    end

    norm_divider u_div (
        .aclk(aclk),
        .aresetn(aresetn),
        .start(div_start_r),
        .dividend(dividend_r),
        .divisor(divisor_r),
        .busy(div_busy),
        .done(div_done),
        .quotient(quotient)
    );

    // normalised value replaces the raw one; saturates at 32 bits
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            freq_value <= '0;
        else if (div_done)
            freq_value <= quotient[DIVIDEND_W-1:32] != '0 ? CNT_SAT
                : quotient[31:0];
    end

    // write channel: address and data taken in either order, then answered
    assign wr_go = aw_hold_r && w_hold_r && !s_axi_bvalid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            awaddr_r <= '0;
            wdata_r <= '0;
            wstrb_r <= '0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_hold_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_hold_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_go)
            begin
                aw_hold_r <= 1'b0;
                w_hold_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= is_mapped(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // configuration registers; writes to read-only words are ignored
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pscale_r <= RST_PSCALE;
            fscale_r <= RST_FSCALE;
            fwindow_r <= RST_FWINDOW;
            freq_norm_numerator_r <= RST_NUMER;
            freq_norm_denominator_r <= RST_DENOM;
        end
        else if (wr_go)
        begin
            unique case (awaddr_r)
                OFS_PSCALE: pscale_r <= merge(pscale_r, wdata_r, wstrb_r);
                OFS_FSCALE: fscale_r <= merge(fscale_r, wdata_r, wstrb_r);
                OFS_FWINDOW: fwindow_r <= merge(fwindow_r, wdata_r, wstrb_r);
                OFS_NUMER: freq_norm_numerator_r <= merge(freq_norm_numerator_r,
                    wdata_r, wstrb_r);
                OFS_DENOM: freq_norm_denominator_r <= merge(freq_norm_denominator_r,
                    wdata_r, wstrb_r);
                default: ;
            endcase
        end
    end

    // read channel: one read at a time, data one clock after address
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            unique case (s_axi_araddr)
                OFS_PSCALE: s_axi_rdata <= pscale_r;
                OFS_FSCALE: s_axi_rdata <= fscale_r;
                OFS_FWINDOW: s_axi_rdata <= fwindow_r;
                OFS_NUMER: s_axi_rdata <= freq_norm_numerator_r;
                OFS_DENOM: s_axi_rdata <= freq_norm_denominator_r;
                OFS_PERIOD: s_axi_rdata <= period_value;
                OFS_FREQ: s_axi_rdata <= freq_value;
                OFS_STATUS: s_axi_rdata <= {29'h0, div_busy, armed_r, timed_out_r};
                default: s_axi_rdata <= '0;
            endcase
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
endmodule // encoder_period_frequency_measure

// >>> verilog/norm_divider.sv
// restoring divider for the frequency normalisation
// one division at a time; start is ignored while busy
`timescale 1ns/1ns
module norm_divider
    import encoder_measure_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic start,
    input wire logic [DIVIDEND_W-1:0] dividend,
    input wire logic [DIVISOR_W-1:0] divisor,
    output logic busy,
    output logic done,
    output logic [DIVIDEND_W-1:0] quotient
);
    logic [DIVISOR_W:0] rem_r;
    logic [DIVIDEND_W-1:0] quo_r;
    logic [DIVISOR_W-1:0] dsr_r;
    logic [6:0] step_r;
    logic [DIVISOR_W:0] shifted;
    logic [DIVISOR_W:0] trial;

    // shift one dividend bit into the remainder per clock
    always_comb
    begin
        shifted = {rem_r[DIVISOR_W-1:0], quo_r[DIVIDEND_W-1]};
        trial = shifted - {1'b0, dsr_r};
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rem_r <= '0;
            quo_r <= '0;
            dsr_r <= '0;
            step_r <= '0;
            busy <= 1'b0;
            done <= 1'b0;
            quotient <= '0;
        end
        else
        begin
            done <= 1'b0;
            if (!busy && start)
            begin
                rem_r <= '0;
                quo_r <= dividend;
                dsr_r <= divisor;
                step_r <= 7'(DIVIDEND_W);
                busy <= 1'b1;
            end
            else if (busy)
            begin
                if (!trial[DIVISOR_W])
                    rem_r <= trial;
                else
                    rem_r <= shifted;
                quo_r <= {quo_r[DIVIDEND_W-2:0], ~trial[DIVISOR_W]};
                step_r <= step_r - 7'h01;
                if (step_r == 7'h01)
                begin
                    busy <= 1'b0;
                    done <= 1'b1;
                    quotient <= {quo_r[DIVIDEND_W-2:0], ~trial[DIVISOR_W]};
                end
            end
        end
    end
endmodule // norm_divider
